// ---- logic/bpxfr_master.sv ----
// master end: runs single and block transfers for a local user
// assumes an outside arbiter answers grant; user holds write data until wnext
`timescale 1ns/10ps
module bpxfr_master (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // backplane
  bpxfr_bus_if.master       bus,
  // arbitration
  input  wire logic [4:0]   arb_prio,
  input  wire logic         grant,
  // request
  input  wire logic         mst_req,
  input  wire logic         mst_write,
  input  wire logic [1:0]   mst_size,
  input  wire logic [31:0]  mst_addr,
  input  wire logic [3:0]   mst_blk_code,
  input  wire logic [31:0]  mst_wdata,
  // answer
  output logic              mst_busy,
  output logic              mst_wnext,
  output logic              mst_rvalid,
  output logic [31:0]       mst_rdata,
  output logic              mst_done,
  output logic [1:0]        mst_status,
  output logic              mst_retry
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    M_IDLE  = 2'h0,
    M_ARB   = 2'h1,
    M_START = 2'h3,
    M_DATA  = 2'h2
  } bpxfr_mst_st_t;

  typedef struct packed {
    bpxfr_mst_st_t st;
    logic          write;
    logic [1:0]    size;
    logic [31:0]   addr;
    logic [3:0]    blk;
    logic [4:0]    left;
    logic [9:0]    cnt;
    logic [31:0]   ad;
    logic          ad_oe;
    logic          start;
    logic [1:0]    tm;
    logic          tm_oe;
    logic          sp;
    logic          spv;
    logic          arb_oe;
    logic [4:0]    arb;
    logic          busy;
    logic          wnext;
    logic          rvalid;
    logic [31:0]   rdata;
    logic          done;
    logic [1:0]    status;
    logic          retry;
  } bpxfr_mst_t;

  bpxfr_mst_t          q;
  bpxfr_mst_t          d;
  bpxfr_pkg::bpxfr_smp_t smp_q;

  // ----------------------------------------------------------------
  // falling-edge capture of the bus
  // ----------------------------------------------------------------
  // half a cycle of settle time hides skew between boards
  always_ff @(negedge mclk) begin
    if (rst) begin
      smp_q <= '0;
    end else begin
      smp_q.ad    <= bus.ad;
      smp_q.tm    <= bus.tm;
      smp_q.start <= 1'b0;
      smp_q.ack   <= bus.s_ack;
      smp_q.sp    <= bus.sp;
      smp_q.spv   <= bus.spv;
    end
  end

  // ----------------------------------------------------------------
  // command and lane decode
  // ----------------------------------------------------------------
  logic        is_byte;
  logic        is_blk;
  logic [1:0]  low_ad;
  logic [31:0] cmd_ad;
  logic [4:0]  sh;
  logic [31:0] wr_word;
  logic [31:0] rd_mask;
  logic [31:0] rd_word;
  logic        rd_perr;

  always_comb begin
    is_byte = (q.size == bpxfr_pkg::SZ_BYTE);
    is_blk  = (q.size == bpxfr_pkg::SZ_BLOCK);
    // width rides on the mode line plus the two low address lines
    if (is_byte) low_ad = q.addr[1:0];
    else if (q.size == bpxfr_pkg::SZ_HALF) low_ad = q.addr[1] ? bpxfr_pkg::A_HALF1
                                                              : bpxfr_pkg::A_HALF0;
    else if (is_blk) low_ad = bpxfr_pkg::A_BLOCK;
    else low_ad = bpxfr_pkg::A_WORD;
    if (is_blk) cmd_ad = {q.addr[31:6], q.blk, low_ad};
    else cmd_ad = {q.addr[31:2], low_ad};
    sh      = bpxfr_pkg::lane_shift(is_byte, low_ad);
    wr_word = mst_wdata << sh;
    if (is_byte) rd_mask = 32'h0000_00ff;
    else if (q.size == bpxfr_pkg::SZ_HALF) rd_mask = 32'h0000_ffff;
    else rd_mask = 32'hffff_ffff;
    rd_word = (smp_q.ad >> sh) & rd_mask;
    rd_perr = !q.write && smp_q.spv && ((^smp_q.ad) != smp_q.sp);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d        = q;
    // priority held in a flop so the arbitration lines never glitch
    d.arb    = arb_prio;
    d.start  = 1'b0;
    d.tm_oe  = 1'b0;
    d.wnext  = 1'b0;
    d.rvalid = 1'b0;
    d.done   = 1'b0;
    d.retry  = 1'b0;
    unique case (q.st)
      M_IDLE: begin
        if (mst_req) begin
          d.write  = mst_write;
          d.size   = mst_size;
          d.addr   = mst_addr;
          d.blk    = mst_blk_code;
          d.status = bpxfr_pkg::ST_ACK;
          d.arb_oe = 1'b1;
          d.st     = M_ARB;
        end
      end
      M_ARB: begin
        // arbitration lines stay live while another transfer is on the bus
        d.arb_oe = !grant;
        if (grant) begin
          d.st    = M_START;
          d.start = 1'b1;
          d.ad    = cmd_ad;
          d.ad_oe = 1'b1;
          d.tm    = {q.write, is_byte};
          d.tm_oe = 1'b1;
          d.sp    = ^cmd_ad;
          d.spv   = bpxfr_pkg::PAR_EN;
          d.left  = is_blk ? bpxfr_pkg::blk_words(q.blk) : 5'h01;
          d.cnt   = '0;
        end
      end
      M_START: begin
        d.st = M_DATA;
        if (q.write) begin
          d.ad    = wr_word;
          d.sp    = ^wr_word;
          d.wnext = 1'b1;
        end else begin
          d.ad_oe = 1'b0;
        end
      end
      M_DATA: begin
        d.cnt = q.cnt + 10'h001;
        if (smp_q.ack) begin
          d.ad_oe  = 1'b0;
          d.status = rd_perr ? bpxfr_pkg::ST_ERR : smp_q.tm;
          d.rdata  = rd_word;
          d.rvalid = !q.write && !rd_perr && (smp_q.tm == bpxfr_pkg::ST_ACK);
          if (smp_q.tm == bpxfr_pkg::ST_RETRY) begin
            // give up and contend again; same command is replayed
            d.retry  = 1'b1;
            d.arb_oe = 1'b1;
            d.st     = M_ARB;
          end else begin
            d.done = 1'b1;
            d.st   = M_IDLE;
          end
        end else if (smp_q.tm[bpxfr_pkg::TM_STRB_BIT] && q.left > 5'h01) begin
          d.left = q.left - 5'h01;
          d.cnt  = '0;
          if (q.write) begin
            d.ad    = mst_wdata;
            d.sp    = ^mst_wdata;
            d.wnext = 1'b1;
          end else begin
            d.rdata  = smp_q.ad;
            d.rvalid = !rd_perr;
          end
        end else if (q.cnt == bpxfr_pkg::MST_LIMIT) begin
          // slave never answered: report timeout ourselves
          d.ad_oe  = 1'b0;
          d.status = bpxfr_pkg::ST_TMO;
          d.done   = 1'b1;
          d.st     = M_IDLE;
        end
      end
    endcase
    d.busy = (d.st != M_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (rst) q <= '0;
    else q <= d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.m_ad     = q.ad;
  assign bus.m_ad_oe  = q.ad_oe;
  assign bus.m_start  = q.start;
  assign bus.m_tm     = q.tm;
  assign bus.m_tm_oe  = q.tm_oe;
  assign bus.m_sp     = q.sp;
  assign bus.m_spv    = q.spv;
  assign bus.m_arb    = q.arb;
  assign bus.m_arb_oe = q.arb_oe;
  assign mst_busy     = q.busy;
  assign mst_wnext    = q.wnext;
  assign mst_rvalid   = q.rvalid;
  assign mst_rdata    = q.rdata;
  assign mst_done     = q.done;
  assign mst_status   = q.status;
  assign mst_retry    = q.retry;

endmodule

// ---- logic/bpxfr_pkg.sv ----
// constants, encodings and lane helpers shared by both ends of the backplane transfer logic
// assumes one 250 MHz clock for both ends; bus levels are active high inside the chip
// How it works
// - address first cycle, data later cycles
// - everything synchronous, whole clock periods
// - drive on rising, sample on falling
// - master asserts start with address, command
// - addressed slave acts, acknowledge ends transfer
// - mode lines give kind and direction
// - mode lines plus low address set width
// - master extracts narrow read lanes itself
// - narrow writes placed on natural lane
// - halfword 1 high, byte 3 topmost
// - block read: command, then ascending words
// - block length 2/4/8/16 on address 5:2
// - block write: write mode, master drives words
// - slave encodes status at acknowledge, master decodes
// - positive status success, error reply failure
// - timeout after N busy cycles
// - retry status: re-arbitrate and repeat
// - parity bit plus parity-valid line
// - slot identity sets module address space
// - sixteen slots, any module any slot
// - arbitration runs beside data transfers
// - interrupts are ordinary writes to watched region
package bpxfr_pkg;

  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned AD_W        = 32;
  localparam int unsigned SLOT_W      = 4;
  localparam int unsigned ARB_W       = 5;
  localparam int unsigned CNT_W       = 10;
  localparam int unsigned CLK_MHZ     = 250;
  localparam int unsigned TIMEOUT_NS  = 1000;
  // longest wait, so round down
  localparam int unsigned TIMEOUT_CYC = (TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam logic [CNT_W-1:0] SLV_LIMIT = CNT_W'(TIMEOUT_CYC - 1);
  // master waits a little longer so the slave's own timeout wins
  localparam logic [CNT_W-1:0] MST_LIMIT = CNT_W'(TIMEOUT_CYC + 8);
  localparam logic PAR_EN = 1'b1;

  // ----------------------------------------------------------------
  // mode line codes
  // ----------------------------------------------------------------
  localparam int unsigned TM_WR_BIT   = 1;
  localparam int unsigned TM_BYTE_BIT = 0;
  localparam int unsigned TM_STRB_BIT = 0;
  localparam logic [1:0] ST_ACK   = 2'h0;
  localparam logic [1:0] ST_ERR   = 2'h1;
  localparam logic [1:0] ST_TMO   = 2'h2;
  localparam logic [1:0] ST_RETRY = 2'h3;
  localparam logic [1:0] A_WORD   = 2'h0;
  localparam logic [1:0] A_HALF0  = 2'h1;
  localparam logic [1:0] A_BLOCK  = 2'h2;
  localparam logic [1:0] A_HALF1  = 2'h3;
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_HALF  = 2'h1;
  localparam logic [1:0] SZ_WORD  = 2'h2;
  localparam logic [1:0] SZ_BLOCK = 2'h3;
  localparam logic [3:0] BLK2     = 4'h1;
  localparam logic [3:0] BLK4     = 4'h3;
  localparam logic [3:0] BLK8     = 4'h7;
  localparam logic [3:0] BLK16    = 4'hf;
  localparam logic [3:0] SLOT_TOP = 4'hf;
  localparam logic [3:0] EV_REGION = 4'hf;

  typedef struct packed {
    logic [AD_W-1:0] ad;
    logic [1:0]      tm;
    logic            start;
    logic            ack;
    logic            sp;
    logic            spv;
  } bpxfr_smp_t;

  // ----------------------------------------------------------------
  // lane helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] lane_be(input logic byte_mode, input logic [1:0] a);
    if (byte_mode) lane_be = 4'h1 << a;
    else if (a == A_HALF0) lane_be = 4'h3;
    else if (a == A_HALF1) lane_be = 4'hc;
    else lane_be = 4'hf;
  endfunction

  function automatic logic [4:0] lane_shift(input logic byte_mode, input logic [1:0] a);
    if (byte_mode) lane_shift = {a, 3'h0};
    else if (a == A_HALF1) lane_shift = 5'h10;
    else lane_shift = 5'h00;
  endfunction

  function automatic logic [4:0] blk_words(input logic [3:0] code);
    unique case (code)
      BLK2:    blk_words = 5'h02;
      BLK4:    blk_words = 5'h04;
      BLK8:    blk_words = 5'h08;
      BLK16:   blk_words = 5'h10;
      default: blk_words = 5'h00;
    endcase
  endfunction

endpackage

// ---- logic/bpxfr_bus_if.sv ----
// backplane lines joining one master end and one slave end
// assumes each party drives only while its enable is high; idle lines read as zero
`timescale 1ns/10ps
interface bpxfr_bus_if;
  // master drive
  logic [31:0] m_ad;
  logic        m_ad_oe;
  logic        m_start;
  logic [1:0]  m_tm;
  logic        m_tm_oe;
  logic        m_sp;
  logic        m_spv;
  logic [4:0]  m_arb;
  logic        m_arb_oe;
  // slave drive
  logic [31:0] s_ad;
  logic        s_ad_oe;
  logic        s_ack;
  logic [1:0]  s_tm;
  logic        s_tm_oe;
  logic        s_sp;
  logic        s_spv;
  // backplane supplied
  logic [3:0]  slot_id;
  // resolved lines
  logic [31:0] ad;
  logic [1:0]  tm;
  logic        sp;
  logic        spv;
  logic [4:0]  arb;

  assign ad  = m_ad_oe ? m_ad : (s_ad_oe ? s_ad : 32'h0000_0000);
  assign sp  = m_ad_oe ? m_sp : (s_ad_oe ? s_sp : 1'b0);
  assign spv = m_ad_oe ? m_spv : (s_ad_oe ? s_spv : 1'b0);
  assign tm  = m_tm_oe ? m_tm : (s_tm_oe ? s_tm : 2'h0);
  assign arb = m_arb_oe ? m_arb : 5'h00;

  modport master (
    output m_ad, m_ad_oe, m_start, m_tm, m_tm_oe, m_sp, m_spv, m_arb, m_arb_oe,
    input  ad, tm, sp, spv, s_ack, arb
  );
  modport slave (
    output s_ad, s_ad_oe, s_ack, s_tm, s_tm_oe, s_sp, s_spv,
    input  ad, tm, sp, spv, m_start, slot_id
  );
endinterface

// ---- logic/bpxfr_slave.sv ----
// slave end: decodes its slot space and hands each word to a local user
// assumes the user answers each request with one rsp_valid pulse
`timescale 1ns/10ps
module bpxfr_slave (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // backplane
  bpxfr_bus_if.slave        bus,
  // request to user
  output logic              usr_req,
  output logic              usr_write,
  output logic [31:0]       usr_addr,
  output logic [3:0]        usr_be,
  output logic [31:0]       usr_wdata,
  output logic              usr_event,
  // user answer
  input  wire logic         rsp_valid,
  input  wire logic [1:0]   rsp_status,
  input  wire logic [31:0]  rsp_rdata
);

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_REQ  = 2'h1,
    S_WAIT = 2'h3
  } bpxfr_slv_st_t;

  typedef struct packed {
    bpxfr_slv_st_t st;
    logic [3:0]    slot_s1;
    logic [3:0]    slot_s2;
    logic [3:0]    slot_s3;
    logic [3:0]    slot;
    logic          write;
    logic [31:0]   addr;
    logic [3:0]    be;
    logic [4:0]    left;
    logic          err;
    logic [9:0]    cnt;
    logic [31:0]   ad;
    logic          ad_oe;
    logic          ack;
    logic [1:0]    tm;
    logic          tm_oe;
    logic          sp;
    logic          spv;
    logic          req;
    logic [31:0]   wdata;
    logic          ev;
  } bpxfr_slv_t;

  bpxfr_slv_t            q;
  bpxfr_slv_t            d;
  bpxfr_pkg::bpxfr_smp_t smp_q;

  // ----------------------------------------------------------------
  // falling-edge capture
  // ----------------------------------------------------------------
  always_ff @(negedge mclk) begin
    if (rst) begin
      smp_q <= '0;
    end else begin
      smp_q.ad    <= bus.ad;
      smp_q.tm    <= bus.tm;
      smp_q.start <= bus.m_start;
      smp_q.ack   <= 1'b0;
      smp_q.sp    <= bus.sp;
      smp_q.spv   <= bus.spv;
    end
  end

  logic hit;
  logic perr;
  logic blk;

  always_comb begin
    // any slot works: the space is wherever the backplane says we sit
    hit  = smp_q.start && (smp_q.ad[31:28] == bpxfr_pkg::SLOT_TOP)
           && (smp_q.ad[27:24] == q.slot);
    perr = smp_q.spv && ((^smp_q.ad) != smp_q.sp);
    blk  = !smp_q.tm[bpxfr_pkg::TM_BYTE_BIT] && (smp_q.ad[1:0] == bpxfr_pkg::A_BLOCK);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    d.slot_s1 = bus.slot_id;
    d.slot_s2 = q.slot_s1;
    d.slot_s3 = q.slot_s2;
    if (q.slot_s2 == q.slot_s3) d.slot = q.slot_s3;
    d.ad_oe = 1'b0;
    d.ack   = 1'b0;
    d.tm_oe = 1'b0;
    d.req   = 1'b0;
    d.ev    = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        if (hit) begin
          d.write = smp_q.tm[bpxfr_pkg::TM_WR_BIT];
          d.err   = perr;
          d.cnt   = '0;
          d.st    = S_REQ;
          if (blk) begin
            d.left = bpxfr_pkg::blk_words(smp_q.ad[5:2]);
            d.addr = {smp_q.ad[31:6], 6'h00};
            d.be   = 4'hf;
            d.err  = perr || (d.left == 5'h00);
          end else begin
            d.left = 5'h01;
            d.addr = smp_q.ad;
            d.be   = bpxfr_pkg::lane_be(smp_q.tm[bpxfr_pkg::TM_BYTE_BIT],
                                        smp_q.ad[1:0]);
          end
        end
      end
      S_REQ: begin
        if (q.cnt != 10'h000) begin
          // next block write word is launched one cycle after our strobe
          d.cnt = 10'h000;
        end else if (q.err || (q.write && perr)) begin
          d.ack   = 1'b1;
          d.tm    = bpxfr_pkg::ST_ERR;
          d.tm_oe = 1'b1;
          d.st    = S_IDLE;
        end else begin
          d.wdata = smp_q.ad;
          d.req = 1'b1;
          // a write into the watched region doubles as an interrupt
          d.ev  = q.write && (q.addr[23:20] == bpxfr_pkg::EV_REGION);
          d.st  = S_WAIT;
        end
      end
      S_WAIT: begin
        d.cnt = q.cnt + 10'h001;
        if (rsp_valid) begin
          d.ad    = rsp_rdata;
          d.sp    = ^rsp_rdata;
          d.spv   = bpxfr_pkg::PAR_EN;
          d.ad_oe = !q.write;
          d.tm_oe = 1'b1;
          if (q.left == 5'h01 || rsp_status != bpxfr_pkg::ST_ACK) begin
            d.ack = 1'b1;
            d.tm  = rsp_status;
            d.st  = S_IDLE;
          end else begin
            d.tm   = 2'h0;
            d.tm[bpxfr_pkg::TM_STRB_BIT] = 1'b1;
            d.left = q.left - 5'h01;
            d.addr = q.addr + 32'h0000_0004;
            d.cnt  = q.write ? 10'h001 : 10'h000;
            d.st   = S_REQ;
          end
        end else if (q.cnt == bpxfr_pkg::SLV_LIMIT) begin
          d.ack   = 1'b1;
          d.tm    = bpxfr_pkg::ST_TMO;
          d.tm_oe = 1'b1;
          d.st    = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) q <= '0;
    else q <= d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.s_ad    = q.ad;
  assign bus.s_ad_oe = q.ad_oe;
  assign bus.s_ack   = q.ack;
  assign bus.s_tm    = q.tm;
  assign bus.s_tm_oe = q.tm_oe;
  assign bus.s_sp    = q.sp;
  assign bus.s_spv   = q.spv;
  assign usr_req     = q.req;
  assign usr_write   = q.write;
  assign usr_addr    = q.addr;
  assign usr_be      = q.be;
  assign usr_wdata   = q.wdata;
  assign usr_event   = q.ev;

endmodule

// ---- sim/bpxfr_sva.sv ----
// line checks between the master and slave ends
// assumes the bench's mclk and rst; sees interface signals only
`timescale 1ns/10ps
module bpxfr_sva (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // master drive
  input wire logic [31:0] m_ad,
  input wire logic        m_ad_oe,
  input wire logic        m_start,
  input wire logic [1:0]  m_tm,
  input wire logic        m_tm_oe,
  // slave drive
  input wire logic        s_ad_oe,
  input wire logic        s_ack,
  input wire logic [1:0]  s_tm,
  input wire logic        s_tm_oe,
  // backplane and resolved lines
  input wire logic [3:0]  slot_id,
  input wire logic [31:0] ad,
  input wire logic        sp,
  input wire logic        spv
);
  // slave timeout plus pipeline slack
  localparam int ACK_MAX = 262;
  logic hit;
  logic blk;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  assign hit = m_ad[31:28] == bpxfr_pkg::SLOT_TOP && m_ad[27:24] == slot_id;
  assign blk = m_ad[1:0] == bpxfr_pkg::A_BLOCK && !m_tm[0];

  a_start_with_cmd: assert property (m_start |-> m_ad_oe && m_tm_oe)
    else $error("start without command drive");
  a_one_txn_open: assert property (m_start && hit |=> !m_start until_with s_ack)
    else $error("second start before acknowledge");
  a_ack_bounded: assert property (m_start && hit && !blk |-> ##[2:ACK_MAX] s_ack)
    else $error("no acknowledge within timeout");
  a_no_contention: assert property (!(m_ad_oe && s_ad_oe))
    else $error("both ends drive the data lines");
  a_parity_valid: assert property (m_ad_oe || s_ad_oe |-> spv && sp == ^ad)
    else $error("parity wrong on a driven word");
  a_ack_status: assert property (s_ack |-> s_tm_oe)
    else $error("acknowledge without status");
  a_ack_single: assert property (s_ack |=> !s_ack)
    else $error("acknowledge longer than one cycle");
  a_read_release: assert property (m_start && !m_tm[1] |=> !m_ad_oe)
    else $error("master holds lines after read command");
  a_slave_drive_gate: assert property (s_ad_oe |-> s_ack || s_tm_oe && s_tm[0])
    else $error("slave drives data without strobe");

  c_write: cover property (m_start && m_tm[1]);
  c_block: cover property (m_start && blk);
  c_timeout: cover property (s_ack && s_tm == bpxfr_pkg::ST_TMO);
endmodule

// ---- sim/bpxfr_tb_top.sv ----
// bench joining one master end to one slave end
// assumes the user-side protocols of both ends as handed over
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module bpxfr_tb_top;
  localparam logic [3:0]  SLOT = 4'h3;
  localparam logic [31:0] BASE = {4'hf, SLOT, 24'h000000};
  logic        mclk, rsp_valid, mst_busy, mst_wnext, mst_rvalid, mst_done, mst_retry;
  logic        rst = 1'b1, grant = 1'b0, mst_req = 1'b0, mst_write = 1'b0;
  logic        mute = 1'b0, retry_once = 1'b0, ev_seen = 1'b0, got_retry;
  logic        usr_req, usr_write, usr_event;
  logic [1:0]  mst_size = 2'h0, rsp_status = 2'h0, st = 2'h0, mst_status, st_tm;
  logic [3:0]  mst_blk_code = 4'h0, usr_be, last_be;
  logic [31:0] mst_addr = 32'h0, mst_wdata = 32'h0, rsp_rdata = 32'h0, mst_rdata;
  logic [31:0] usr_addr, usr_wdata, last_wd, st_ad, mem [64], rd [16];
  logic [3:0]  codes [4] = '{bpxfr_pkg::BLK2, bpxfr_pkg::BLK4, bpxfr_pkg::BLK8, bpxfr_pkg::BLK16};
  int          nw [4] = '{2, 4, 8, 16};
  int          error_cnt = 0, num_checks = 0, nrd, dly = 1, cnt = 0, req_cnt = 0, cyc = 0, wt;
  int          req_snap;

  bpxfr_bus_if bus ();
  assign bus.slot_id = SLOT;

  bpxfr_master bpxfr_master_inst (.mclk(mclk), .rst(rst), .bus(bus.master), .arb_prio(5'h0a),
    .grant(grant), .mst_req(mst_req), .mst_write(mst_write), .mst_size(mst_size),
    .mst_addr(mst_addr), .mst_blk_code(mst_blk_code), .mst_wdata(mst_wdata),
    .mst_busy(mst_busy), .mst_wnext(mst_wnext), .mst_rvalid(mst_rvalid), .mst_rdata(mst_rdata),
    .mst_done(mst_done), .mst_status(mst_status), .mst_retry(mst_retry));
  bpxfr_slave bpxfr_slave_inst (.mclk(mclk), .rst(rst), .bus(bus.slave), .usr_req(usr_req),
    .usr_write(usr_write), .usr_addr(usr_addr), .usr_be(usr_be), .usr_wdata(usr_wdata),
    .usr_event(usr_event), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
    .rsp_rdata(rsp_rdata));
  bpxfr_sva bpxfr_sva_inst (.mclk(mclk), .rst(rst), .m_ad(bus.m_ad), .m_ad_oe(bus.m_ad_oe),
    .m_start(bus.m_start), .m_tm(bus.m_tm), .m_tm_oe(bus.m_tm_oe), .s_ad_oe(bus.s_ad_oe),
    .s_ack(bus.s_ack), .s_tm(bus.s_tm), .s_tm_oe(bus.s_tm_oe), .slot_id(bus.slot_id),
    .ad(bus.ad), .sp(bus.sp), .spv(bus.spv));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------
  // slave user: memory with dly-cycle answer
  // ----------------------------------------
  always @(posedge mclk) begin
    rsp_valid <= 1'b0;
    cyc <= cyc + 1;
    if (cnt != 0) cnt <= cnt - 1;
    if (cnt == 1) begin
      rsp_valid <= 1'b1;
      rsp_status <= retry_once ? bpxfr_pkg::ST_RETRY : st;
      retry_once <= 1'b0;
      rsp_rdata <= mem[usr_addr[7:2]];
    end
    if (usr_req === 1'b1) begin
      req_cnt <= req_cnt + 1;
      last_be <= usr_be;
      last_wd <= usr_wdata;
      if (usr_event === 1'b1) ev_seen <= 1'b1;
      for (int b = 0; b < 4; b++)
        if (usr_write && usr_be[b]) mem[usr_addr[7:2]][8*b+:8] <= usr_wdata[8*b+:8];
      if (!mute) cnt <= dly;
    end
    // command word as seen on the wire
    if (bus.m_start === 1'b1) begin
      st_ad <= bus.ad;
      st_tm <= bus.tm;
    end
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [1:0] sz, input logic [31:0] a,
                      input logic [3:0] bc, input logic [31:0] d0);
    int k;
    k = 0;
    wt = 0;
    nrd = 0;
    got_retry = 1'b0;
    mst_req <= 1'b1;
    mst_write <= w;
    mst_size <= sz;
    mst_addr <= a;
    mst_blk_code <= bc;
    mst_wdata <= d0;
    @(posedge mclk);
    mst_req <= 1'b0;
    do begin
      @(posedge mclk);
      wt++;
      // a replayed block write restarts from its first word
      if (mst_retry === 1'b1) begin
        k = 0;
        got_retry = 1'b1;
        mst_wdata <= d0;
      end else if (mst_wnext === 1'b1) begin
        k++;
        mst_wdata <= d0 + k;
      end
      if (mst_rvalid === 1'b1 && nrd < 16) begin
        rd[nrd] = mst_rdata;
        nrd++;
      end
    end while (mst_done !== 1'b1 && wt < 6000);
    `CHK("done", 1'b1, mst_done)
    `CHK("busy", 1'b0, mst_busy)
  endtask

  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    grant <= 1'b1;
    // slot synchroniser must settle before the first start
    repeat (5) @(posedge mclk);
    xfer(1'b1, bpxfr_pkg::SZ_WORD, BASE + 32'h10, 4'h0, 32'hcafe_0001);
    `CHK("cmd ad", BASE + 32'h10, st_ad)
    `CHK("cmd tm", 2'h2, st_tm)
    `CHK("status", bpxfr_pkg::ST_ACK, mst_status)
    xfer(1'b0, bpxfr_pkg::SZ_WORD, BASE + 32'h10, 4'h0, 32'h0);
    `CHK("word", 32'hcafe_0001, rd[0])
    `CHK("ev", 1'b0, ev_seen)
    $display("test word done");
    for (int b = 0; b < 4; b++) begin
      xfer(1'b1, bpxfr_pkg::SZ_BYTE, BASE + 32'h20 + b, 4'h0, 32'ha0 + b);
      `CHK("cmd tm", 2'h3, st_tm)
      `CHK("be", 4'h1 << b, last_be)
      `CHK("lane", 8'ha0 + b, last_wd[8*b+:8])
    end
    for (int b = 0; b < 4; b++) begin
      xfer(1'b0, bpxfr_pkg::SZ_BYTE, BASE + 32'h20 + b, 4'h0, 32'h0);
      `CHK("byte", 8'ha0 + b, rd[0][7:0])
    end
    xfer(1'b1, bpxfr_pkg::SZ_HALF, BASE + 32'h22, 4'h0, 32'h5a5a);
    `CHK("be", 4'hc, last_be)
    xfer(1'b0, bpxfr_pkg::SZ_WORD, BASE + 32'h20, 4'h0, 32'h0);
    `CHK("lanes", 32'h5a5a_a1a0, rd[0])
    xfer(1'b0, bpxfr_pkg::SZ_HALF, BASE + 32'h20, 4'h0, 32'h0);
    `CHK("half", 16'ha1a0, rd[0][15:0])
    $display("test lanes done");
    for (int i = 0; i < 4; i++) begin
      dly = 1 + i;
      xfer(1'b1, bpxfr_pkg::SZ_BLOCK, BASE + 32'h80, codes[i], 32'hb000000 + 32'(i << 16));
      `CHK("blk code", codes[i], st_ad[5:2])
      `CHK("status", bpxfr_pkg::ST_ACK, mst_status)
      xfer(1'b0, bpxfr_pkg::SZ_BLOCK, BASE + 32'h80, codes[i], 32'h0);
      `CHK("count", nw[i], nrd)
      for (int j = 0; j < nw[i]; j++)
        `CHK("blk word", 32'h0b00_0000 + 32'(i << 16) + 32'(j), rd[j])
    end
    dly = 1;
    $display("test block done");
    st = bpxfr_pkg::ST_ERR;
    xfer(1'b1, bpxfr_pkg::SZ_WORD, BASE + 32'h30, 4'h0, 32'h1);
    `CHK("status", bpxfr_pkg::ST_ERR, mst_status)
    st = bpxfr_pkg::ST_ACK;
    retry_once = 1'b1;
    xfer(1'b1, bpxfr_pkg::SZ_WORD, BASE + 32'h30, 4'h0, 32'h77);
    `CHK("retry", 1'b1, got_retry)
    `CHK("status", bpxfr_pkg::ST_ACK, mst_status)
    $display("test status done");
    mute = 1'b1;
    xfer(1'b0, bpxfr_pkg::SZ_WORD, BASE + 32'h10, 4'h0, 32'h0);
    `CHK("status", bpxfr_pkg::ST_TMO, mst_status)
    `CHK("wait", 1'b1, wt >= 250 && wt <= 270)
    mute = 1'b0;
    req_snap = req_cnt;
    xfer(1'b0, bpxfr_pkg::SZ_WORD, {4'hf, 4'h5, 24'h000010}, 4'h0, 32'h0);
    `CHK("miss", bpxfr_pkg::ST_TMO, mst_status)
    `CHK("req", req_snap, req_cnt)
    $display("test timeout done");
    xfer(1'b1, bpxfr_pkg::SZ_WORD, BASE | 32'h00f0_0000, 4'h0, 32'h1);
    `CHK("ev", 1'b1, ev_seen)
    $display("test event done");
    give_verdict();
  end
endmodule
